// ==== dltpc_map.vh ====
`ifndef DLTPC_MAP_VH
`define DLTPC_MAP_VH

// ==========================================================
// Register offsets
`define DLTPC_OFS_EQCFG      8'h05
`define DLTPC_OFS_PINCTL     8'h06
`define DLTPC_OFS_EVSTAT     8'h10
`define DLTPC_OFS_EVCLR      8'h11
`define DLTPC_OFS_EVEN       8'h12

// ==========================================================
// Field positions, equalizer and bridge register
`define DLTPC_BIT_ADDR_OMIT  7
`define DLTPC_CUT_HI         6
`define DLTPC_CUT_LO         5
`define DLTPC_BIT_HF_OFF     4
`define DLTPC_GAIN_HI        3
`define DLTPC_GAIN_LO        0

// ==========================================================
// Field positions, pin and interrupt register
`define DLTPC_BIT_STAG_OFF   7
`define DLTPC_BIT_AUTO_CLR   6
`define DLTPC_BIT_FWD_OFF    5
`define DLTPC_BIT_INT_LVL    4
`define DLTPC_BIT_P1_DRV     3
`define DLTPC_BIT_P1_LVL     2
`define DLTPC_BIT_P0_DRV     1
`define DLTPC_BIT_P0_LVL     0

// ==========================================================
// Event bits
`define DLTPC_EV_INT_RISE    0
`define DLTPC_EV_P1_CHG      1
`define DLTPC_EV_P0_CHG      2
`define DLTPC_EV_BAD_GAIN    3

// ==========================================================
// Reset values and gain limit
`define DLTPC_RST_CUTOFF     2'h1
`define DLTPC_RST_GAIN_HI    4'h4
`define DLTPC_RST_GAIN_LO    4'h9
`define DLTPC_RST_PINCTL     8'h0A
`define DLTPC_GAIN_MAX       4'hB

// ==========================================================
// Timing
`define DLTPC_STRAP_CNT      2'h2

`endif

// ==== dltpc_sync2.v ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for slow pin levels
module dltpc_sync2 #(
    parameter W = 4
) (
    input  wire         core_clk,
    input  wire         nrst,
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut
);
    reg [W-1:0] meta_q;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q  <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

`default_nettype wire

// ==== dltpc_regs.v ====
// How it works
// R1 - Address-omit bit 0 sends register address in bridging; 1 is command-byte-only; resets 0.
// R2 - Two-bit cutoff selects 7.5, 3.75, 2.5, 1.87 MHz; defaults to 01.
// R3 - Gain codes 0000..1011 give rising boost; 11XX codes are invalid.
// R4 - Gain powers up 0100 with select pin high, 1001 with it low.
// R5 - Auto-clear bit 1 clears error registers and outputs automatically; defaults 0.
// R6 - Forward-off bit 0 sends interrupt events to serializer; 1 suppresses; default 0.
// R7 - Read-only bit shows present level of interrupt input pin.
// R8 - Pin one drive bit sets its level, default 1; separate bit reads level.
// R9 - Pin zero drive bit sets its level, default 1; separate bit reads level.
// R10 - Writes to level bits are ignored; they always show sampled pins.
// R11 - Boost-off and stagger-off bits are active high disables, both default 0.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "dltpc_map.vh"

module dltpc_regs (
    input  wire       core_clk,
    input  wire       nrst,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdata,
    input  wire       eqDefaultSelectPin,
    input  wire       intPinIn,
    input  wire       pinOneIn,
    input  wire       pinZeroIn,
    input  wire       errorEvent,
    output reg        pinOneOut,
    output reg        pinOneOe,
    output reg        pinZeroOut,
    output reg        pinZeroOe,
    output reg        bridgeAddressOmit,
    output reg  [1:0] eqHighpassCutoffSel,
    output reg        hfBoostOff,
    output reg  [3:0] eqBoostGainSel,
    output reg        outputStaggerOff,
    output reg        errorAutoClear,
    output reg        remoteEventForward,
    output reg        irq
);
    // ==========================================================
    // Pin sampling
    wire [3:0] pinSync;
    wire       eqsLvl  = pinSync[3];
    wire       intLvl  = pinSync[2];
    wire       p1Lvl   = pinSync[1];
    wire       p0Lvl   = pinSync[0];

    dltpc_sync2 #(.W(4)) uSync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .asyncIn  ({eqDefaultSelectPin, intPinIn, pinOneIn, pinZeroIn}),
        .syncOut  (pinSync)
    );

    // ==========================================================
    // Configuration state
    reg       addrOmit_q;
    reg [1:0] cutoff_q;
    reg       hfOff_q;
    reg [3:0] gain_q;
    reg       stagOff_q;
    reg       autoClr_q;
    reg       fwdOff_q;
    reg       p1Drv_q;
    reg       p0Drv_q;
    reg [1:0] strapCnt_q;
    reg       strapDone_q;
    reg       intLvl_q;
    reg       p1Lvl_q;
    reg       p0Lvl_q;
    reg [3:0] evStat_q;
    reg [3:0] evEn_q;
    reg       fwdPend_q;
    reg       addrOmit_d;
    reg [1:0] cutoff_d;
    reg       hfOff_d;
    reg [3:0] gain_d;
    reg       stagOff_d;
    reg       autoClr_d;
    reg       fwdOff_d;
    reg       p1Drv_d;
    reg       p0Drv_d;
    reg [3:0] evClr;
    reg [3:0] evStat_d;
    reg [3:0] evEn_d;
    reg [7:0] rdData_d;
    wire      strapNow;

    function hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = strobe && (addr == ofs);
        end
    endfunction

    wire wrEq   = hit(regWr, regAddr, `DLTPC_OFS_EQCFG);
    wire wrPin  = hit(regWr, regAddr, `DLTPC_OFS_PINCTL);
    wire wrClr  = hit(regWr, regAddr, `DLTPC_OFS_EVCLR);
    wire wrEn   = hit(regWr, regAddr, `DLTPC_OFS_EVEN);

    function badGain;
        input [3:0] g;
        begin
            badGain = (g > `DLTPC_GAIN_MAX); // R3
        end
    endfunction

    // Strap caught two cycles after release, once the synchroniser has settled
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strapCnt_q  <= 2'h0;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapCnt_q <= strapCnt_q + 2'h1;
            if (strapCnt_q == `DLTPC_STRAP_CNT) begin
                strapDone_q <= 1'b1;
            end
        end
    end

    assign strapNow = !strapDone_q && (strapCnt_q == `DLTPC_STRAP_CNT);

    // ==========================================================
    // Equalizer and bridge register
    // A write in the strap cycle wins; a refused gain code leaves the strap
    always @* begin
        addrOmit_d = addrOmit_q;
        cutoff_d   = cutoff_q;
        hfOff_d    = hfOff_q;
        gain_d     = gain_q;
        if (strapNow) begin
            gain_d = eqsLvl ? `DLTPC_RST_GAIN_HI : `DLTPC_RST_GAIN_LO; // R4
        end
        if (wrEq) begin
            addrOmit_d = regWdata[`DLTPC_BIT_ADDR_OMIT]; // R1
            cutoff_d   = regWdata[`DLTPC_CUT_HI:`DLTPC_CUT_LO]; // R2
            hfOff_d    = regWdata[`DLTPC_BIT_HF_OFF]; // R11
            // Invalid codes are refused; the previous gain stays
            if (!badGain(regWdata[`DLTPC_GAIN_HI:`DLTPC_GAIN_LO])) begin
                gain_d = regWdata[`DLTPC_GAIN_HI:`DLTPC_GAIN_LO]; // R3
            end
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addrOmit_q <= 1'b0; // R1
            cutoff_q   <= `DLTPC_RST_CUTOFF; // R2
            hfOff_q    <= 1'b0; // R11
            gain_q     <= `DLTPC_RST_GAIN_LO; // R4
        end else begin
            addrOmit_q <= addrOmit_d;
            cutoff_q   <= cutoff_d;
            hfOff_q    <= hfOff_d;
            gain_q     <= gain_d;
        end
    end

    // ==========================================================
    // Pin and interrupt register
    // Level bits have no storage, so writes to them fall away
    always @* begin
        stagOff_d = stagOff_q;
        autoClr_d = autoClr_q;
        fwdOff_d  = fwdOff_q;
        p1Drv_d   = p1Drv_q;
        p0Drv_d   = p0Drv_q;
        if (wrPin) begin
            stagOff_d = regWdata[`DLTPC_BIT_STAG_OFF]; // R11
            autoClr_d = regWdata[`DLTPC_BIT_AUTO_CLR]; // R5
            fwdOff_d  = regWdata[`DLTPC_BIT_FWD_OFF]; // R6
            p1Drv_d   = regWdata[`DLTPC_BIT_P1_DRV]; // R8
            p0Drv_d   = regWdata[`DLTPC_BIT_P0_DRV]; // R9
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stagOff_q <= 1'b0; // R11
            autoClr_q <= 1'b0; // R5
            fwdOff_q  <= 1'b0; // R6
            p1Drv_q   <= 1'b1; // R8
            p0Drv_q   <= 1'b1; // R9
        end else begin
            stagOff_q <= stagOff_d;
            autoClr_q <= autoClr_d;
            fwdOff_q  <= fwdOff_d;
            p1Drv_q   <= p1Drv_d;
            p0Drv_q   <= p0Drv_d;
        end
    end

    // ==========================================================
    // Events
    // Edges count only once the synchroniser has settled after reset,
    // so the release of reset never looks like a pin change
    wire [3:0] evSet;
    assign evSet[`DLTPC_EV_INT_RISE] = strapDone_q && intLvl && !intLvl_q;
    assign evSet[`DLTPC_EV_P1_CHG]   = strapDone_q && (p1Lvl ^ p1Lvl_q);
    assign evSet[`DLTPC_EV_P0_CHG]   = strapDone_q && (p0Lvl ^ p0Lvl_q);
    assign evSet[`DLTPC_EV_BAD_GAIN] = wrEq && badGain(regWdata[3:0]); // R3

    // Auto-clear of the bad-gain event, held off while the error input is high
    wire autoClrNow = autoClr_q && !errorEvent; // R5

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intLvl_q  <= 1'b0;
            p1Lvl_q   <= 1'b0;
            p0Lvl_q   <= 1'b0;
            evStat_q  <= 4'h0;
            evEn_q    <= 4'h0;
            fwdPend_q <= 1'b0;
        end else begin
            intLvl_q  <= intLvl;
            p1Lvl_q   <= p1Lvl;
            p0Lvl_q   <= p0Lvl;
            evStat_q  <= evStat_d;
            evEn_q    <= evEn_d;
            fwdPend_q <= !fwdOff_q && evSet[`DLTPC_EV_INT_RISE]; // R6
        end
    end

    // Set beats clear in the same cycle
    always @* begin
        evClr = 4'h0;
        if (wrClr) begin
            evClr = regWdata[3:0];
        end
        if (autoClrNow) begin
            evClr[`DLTPC_EV_BAD_GAIN] = 1'b1; // R5
        end
        evStat_d = (evStat_q & ~evClr) | evSet;
        evEn_d   = wrEn ? regWdata[3:0] : evEn_q;
    end

    // ==========================================================
    // Read path and registered outputs
    // Idle cycles read back zero, so stale data never lingers on the bus
    always @* begin
        rdData_d = 8'h00;
        if (regRd) begin
            case (regAddr)
                `DLTPC_OFS_EQCFG:  rdData_d = {addrOmit_q, cutoff_q, hfOff_q, gain_q};
                `DLTPC_OFS_PINCTL: rdData_d = {stagOff_q, autoClr_q, fwdOff_q,
                                               intLvl, p1Drv_q, p1Lvl,
                                               p0Drv_q, p0Lvl}; // R7 R10
                `DLTPC_OFS_EVSTAT: rdData_d = {4'h0, evStat_q};
                `DLTPC_OFS_EVEN:   rdData_d = {4'h0, evEn_q};
                default:           rdData_d = 8'h00;
            endcase
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= rdData_d;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinOneOut           <= 1'b1;
            pinOneOe            <= 1'b0;
            pinZeroOut          <= 1'b1;
            pinZeroOe           <= 1'b0;
            bridgeAddressOmit   <= 1'b0;
            eqHighpassCutoffSel <= `DLTPC_RST_CUTOFF;
            hfBoostOff          <= 1'b0;
            eqBoostGainSel      <= `DLTPC_RST_GAIN_LO;
            outputStaggerOff    <= 1'b0;
            errorAutoClear      <= 1'b0;
            remoteEventForward  <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            pinOneOut           <= p1Drv_q; // R8
            pinOneOe            <= 1'b1;
            pinZeroOut          <= p0Drv_q; // R9
            pinZeroOe           <= 1'b1;
            bridgeAddressOmit   <= addrOmit_q; // R1
            eqHighpassCutoffSel <= cutoff_q; // R2
            hfBoostOff          <= hfOff_q; // R11
            eqBoostGainSel      <= gain_q; // R3
            outputStaggerOff    <= stagOff_q; // R11
            errorAutoClear      <= autoClr_q; // R5
            remoteEventForward  <= fwdPend_q; // R6
            irq                 <= |(evStat_q & evEn_q);
        end
    end
endmodule

`default_nettype wire

// ==== dltpc_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module dltpc_regs_sva (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       intPinIn,
    input wire logic       pinOneOut,
    input wire logic       pinZeroOut,
    input wire logic       bridgeAddressOmit,
    input wire logic [1:0] eqHighpassCutoffSel,
    input wire logic [3:0] eqBoostGainSel,
    input wire logic       errorAutoClear,
    input wire logic       remoteEventForward,
    input wire logic       irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic fwdOff_q;
    wire  eqWr  = regWr && regAddr == 8'h05;
    wire  pinWr = regWr && regAddr == 8'h06;
    // Shadow of forward-off, loaded on the same write edge as the register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) fwdOff_q <= 1'b0;
        else if (pinWr) fwdOff_q <= regWdata[5];
    end
    // ==========
    // Assertions
    omit_follows_a: assert property (eqWr |=> ##1 bridgeAddressOmit == $past(regWdata[7], 2))
        else $error("address omit not taken");
    cutoff_follows_a: assert property (eqWr |=> ##1
        eqHighpassCutoffSel == $past(regWdata[6:5], 2))
        else $error("cutoff not taken");
    bad_gain_a: assert property (eqWr && regWdata[3:2] == 2'b11 |=> ##1 $stable(eqBoostGainSel))
        else $error("invalid gain accepted");
    auto_clear_a: assert property (pinWr |=> ##1 errorAutoClear == $past(regWdata[6], 2))
        else $error("auto clear not taken");
    // The pulse leaves two edges after the event, judged by the setting then
    fwd_quiet_a: assert property (remoteEventForward |-> !$past(fwdOff_q, 2))
        else $error("event sent while forwarding off");
    int_level_a: assert property (($stable(intPinIn)[*4] ##0
        (regRd && regAddr == 8'h06)) |=> regRdata[4] == $past(intPinIn))
        else $error("interrupt level readback wrong");
    p1_drive_a: assert property (pinWr |=> ##1 pinOneOut == $past(regWdata[3], 2))
        else $error("pin one drive wrong");
    p0_drive_a: assert property (pinWr |=> ##1 pinZeroOut == $past(regWdata[1], 2))
        else $error("pin zero drive wrong");
    cover property (eqWr && regWdata[3:2] == 2'b11);
    cover property (remoteEventForward);
    cover property ($rose(irq));
endmodule
bind dltpc_regs dltpc_regs_sva u_sva (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .regAddr             (regAddr),
    .regWdata            (regWdata),
    .regWr               (regWr),
    .regRd               (regRd),
    .regRdata            (regRdata),
    .intPinIn            (intPinIn),
    .pinOneOut           (pinOneOut),
    .pinZeroOut          (pinZeroOut),
    .bridgeAddressOmit   (bridgeAddressOmit),
    .eqHighpassCutoffSel (eqHighpassCutoffSel),
    .eqBoostGainSel      (eqBoostGainSel),
    .errorAutoClear      (errorAutoClear),
    .remoteEventForward  (remoteEventForward),
    .irq                 (irq)
);
`default_nettype wire

// ==== dltpc_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dltpc_pad_model (
    input  wire logic pinOneOut,
    input  wire logic pinOneOe,
    input  wire logic pinZeroOut,
    input  wire logic pinZeroOe,
    input  wire logic padPullLow,
    output wire logic pinOneIn,
    output wire logic pinZeroIn
);
    // Pads pulled up when released; padPullLow overdrives both
    assign pinOneIn  = (pinOneOe ? pinOneOut : 1'b1) & ~padPullLow;
    assign pinZeroIn = (pinZeroOe ? pinZeroOut : 1'b1) & ~padPullLow;
endmodule
`default_nettype wire

// ==== dltpc_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dltpc_regs_tb;
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic       eqDefaultSelectPin = 1'b0;
    logic       intPinIn = 1'b0;
    logic       errorEvent = 1'b0;
    logic       padPullLow = 1'b0;
    wire  [7:0] regRdata;
    wire  [1:0] eqHighpassCutoffSel;
    wire  [3:0] eqBoostGainSel;
    wire        pinOneOut, pinOneOe, pinZeroOut, pinZeroOe, pinOneIn, pinZeroIn;
    wire        bridgeAddressOmit, hfBoostOff, outputStaggerOff, errorAutoClear;
    wire        remoteEventForward, irq;
    int         err_count = 0;
    int         compares = 0;
    int         cyc = 0;
    int         fwdSeen = 0;
    initial forever #20 core_clk = ~core_clk;
    dltpc_regs dut (
        .core_clk            (core_clk),
        .nrst                (nrst),
        .regAddr             (regAddr),
        .regWdata            (regWdata),
        .regWr               (regWr),
        .regRd               (regRd),
        .regRdata            (regRdata),
        .eqDefaultSelectPin  (eqDefaultSelectPin),
        .intPinIn            (intPinIn),
        .pinOneIn            (pinOneIn),
        .pinZeroIn           (pinZeroIn),
        .errorEvent          (errorEvent),
        .pinOneOut           (pinOneOut),
        .pinOneOe            (pinOneOe),
        .pinZeroOut          (pinZeroOut),
        .pinZeroOe           (pinZeroOe),
        .bridgeAddressOmit   (bridgeAddressOmit),
        .eqHighpassCutoffSel (eqHighpassCutoffSel),
        .hfBoostOff          (hfBoostOff),
        .eqBoostGainSel      (eqBoostGainSel),
        .outputStaggerOff    (outputStaggerOff),
        .errorAutoClear      (errorAutoClear),
        .remoteEventForward  (remoteEventForward),
        .irq                 (irq)
    );
    dltpc_pad_model pads (
        .pinOneOut           (pinOneOut),
        .pinOneOe            (pinOneOe),
        .pinZeroOut          (pinZeroOut),
        .pinZeroOe           (pinZeroOe),
        .padPullLow          (padPullLow),
        .pinOneIn            (pinOneIn),
        .pinZeroIn           (pinZeroIn)
    );
    // ==========
    // Monitor and hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (remoteEventForward === 1'b1) fwdSeen++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Strobe then one idle edge, so no strobe is assigned twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        idle(1);
        regWr <= 1'b0;
        idle(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        idle(1);
        regRd <= 1'b0;
        // Read data stand only in this cycle; look mid-cycle, clear of the edge
        @(negedge core_clk);
        chk($sformatf("reg %h", a), exp, regRdata);
        idle(1);
    endtask
    task automatic do_reset(input logic strap);
        nrst <= 1'b0;
        eqDefaultSelectPin <= strap;
        idle(2);
        nrst <= 1'b1;
        idle(6);
    endtask
    task automatic t_defaults(input logic [3:0] g);
        rd(8'h05, {4'h2, g});
        rd(8'h06, 8'h0F);
    endtask
    task automatic t_cfg();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1:0], i[1], 4'hB - 4'(i)};
            wr(8'h05, d);
            rd(8'h05, d);
            chk("cutoff", {6'h00, i[1:0]}, {6'h00, eqHighpassCutoffSel});
            chk("gain", {4'h0, d[3:0]}, {4'h0, eqBoostGainSel});
            chk("omit", {7'h00, d[7]}, {7'h00, bridgeAddressOmit});
            chk("hf off", {7'h00, d[4]}, {7'h00, hfBoostOff});
        end
    endtask
    task automatic t_badgain();
        wr(8'h11, 8'hFF);
        wr(8'h05, 8'h0C);
        rd(8'h05, 8'h08);
        rd(8'h10, 8'h08);
        wr(8'h12, 8'h08);
        idle(2);
        chk("irq set", 8'h01, {7'h00, irq});
        wr(8'h11, 8'h08);
        idle(2);
        chk("irq clear", 8'h00, {7'h00, irq});
        errorEvent <= 1'b1;
        wr(8'h05, 8'h0C);
        wr(8'h06, 8'h4A);
        idle(2);
        rd(8'h10, 8'h08);
        chk("auto clear", 8'h01, {7'h00, errorAutoClear});
        errorEvent <= 1'b0;
        idle(2);
        rd(8'h10, 8'h00);
        wr(8'h06, 8'h0A);
    endtask
    task automatic t_pins();
        wr(8'h06, 8'h15);
        idle(4);
        rd(8'h06, 8'h00);
        wr(8'h06, 8'h0A);
        padPullLow <= 1'b1;
        idle(4);
        rd(8'h06, 8'h0A);
        padPullLow <= 1'b0;
        fwdSeen = 0;
        intPinIn <= 1'b1;
        idle(5);
        rd(8'h06, 8'h1F);
        chk("forward pulses", 8'h01, 8'(fwdSeen));
        wr(8'h06, 8'h2A);
        intPinIn <= 1'b0;
        idle(3);
        intPinIn <= 1'b1;
        idle(6);
        chk("forward pulses", 8'h01, 8'(fwdSeen));
        wr(8'h06, 8'h8A);
        rd(8'h06, 8'h9F);
        chk("stagger off", 8'h01, {7'h00, outputStaggerOff});
    endtask
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        t_defaults(4'h9);
        do_reset(1'b1);
        t_defaults(4'h4);
        t_cfg();
        t_badgain();
        t_pins();
        results();
    end
endmodule
`default_nettype wire
